// ### src/pwm_timer_pkg.sv
// Shared constants of the center/complementary PWM timer: register map, field layout, reset values.
// Assumes a 32-bit APB register bus with byte addresses and one timer clock.
package pwm_timer_pkg;

  // ==========================================================================
  // Sizes
  localparam int CNT_W = 16;
  localparam int NUM_CH = 8;
  localparam int NUM_PAIR = 4;
  localparam int DT_W = 6;
  localparam int ADDR_W = 8;

  // ==========================================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_SC = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CNT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MOD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INIT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PAIR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_DEAD = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_SUMMARY = 8'h1c;
  // Channel n status/control at 8'h40 + 8n, its value at 8'h44 + 8n.
  localparam logic [1:0] CH_REGION = 2'h1;

  // ==========================================================================
  // Field positions
  localparam int SC_TOF = 7;
  localparam int SC_OVERFLOW_IRQ_ENABLE = 6;
  localparam int SC_CENTER = 5;
  localparam int SC_RUN = 3;
  localparam int MODE_WPDIS = 0;
  localparam int MODE_EXT = 1;
  localparam int MODE_QUAD = 2;
  localparam int PAIR_STRIDE = 8;
  localparam int PF_COMBINE = 0;
  localparam int PF_COMP = 1;
  localparam int PF_DECAP = 2;
  localparam int PF_DTE = 4;
  localparam int CH_FLAG = 7;
  localparam int CH_IE = 6;
  localparam int CH_MS_HI = 5;
  localparam int CH_MS_LO = 4;
  localparam int CH_ELS_HI = 3;
  localparam int CH_ELS_LO = 2;

  // ==========================================================================
  // Encodings and reset values
  localparam logic [1:0] MS_COMPARE = 2'h1;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] INIT_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [DT_W-1:0] DT_ZERO = 6'h00;
  localparam logic [DT_W-1:0] DT_ONE = 6'h01;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage : pwm_timer_pkg

// ### src/dead_gap.sv
// One output of a complementary pair with its dead interval.
// Assumes the caller supplies the undelayed level and the gap length in timer clocks.
`timescale 1ns/10ps
module dead_gap (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Gap control
  input wire logic i_en,
  input wire logic [pwm_timer_pkg::DT_W-1:0] i_len,
  // Level in and out
  input wire logic i_in,
  output logic o_out
);
  import pwm_timer_pkg::*;

  logic [DT_W-1:0] wait_cnt;
  logic [DT_W-1:0] next_wait_cnt;
  logic next_out;

  // ==========================================================================
  // Only the inactive-to-active edge waits; falling is immediate so both sides are low in the gap.
  always_comb begin
    next_wait_cnt = DT_ZERO;
    next_out = 1'b0;
    if (!i_en) begin
      next_out = i_in;
    end else if (i_in) begin
      if (wait_cnt >= i_len) begin
        next_out = 1'b1;
        next_wait_cnt = wait_cnt;
      end else begin
        next_wait_cnt = wait_cnt + DT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wait_cnt <= DT_ZERO;
      o_out <= 1'b0;
    end else begin
      wait_cnt <= next_wait_cnt;
      o_out <= next_out;
    end
  end

endmodule : dead_gap

// ### src/pwm_timer.sv
// Eight-channel timer/PWM with one shared counter, complementary pairs, dead time and combined pairs.
// Assumes an APB master on the timer clock; the PWM pins feed gate drivers outside.
// How it works
// - Center mode counts initial value up to modulo, then back down, repeatedly.
// - Center-mode levels derive from the counter value, so pulses are symmetric about initial value.
// - Center counting needs quadrature, dual capture, combine clear and center bit set.
// - Complementary pair without dead time: odd output is the inverse of even.
// - Complement bit set makes a pair complementary in edge or center counting.
// - Dead-time bit set together with complement bit keeps both pair outputs inactive around each transition.
// - Combined pair needs extended, no quadrature, no dual capture, combine, no center, complement.
// - Combined pairs work only with up-counting; center bit disables combining.
// - Combined even output is active between even match and odd match.
// - Mode select 01 with edge/level 01 and plain pair makes a toggle divider.
// - Divider output toggles at each match, period twice the counter span.
// - All channels share one counter; in the toggle divider the channel value only sets the phase.
// - Counter matching channel value sets its flag; with enable it interrupts.
// - Counter wraparound sets overflow flag; with its enable it interrupts.
// - Overflow recurs once per counter period; a match once in edge counting, twice in center counting unless at modulo or initial value.
// - All sources merge onto one interrupt line; software finds and clears flags.
// - A summary register shows all channel flags in one read.
// - Edge counting reloads initial value after modulo; outputs change on matches.
// - Edge period is modulo minus initial plus one; width set by channel value.
// - Edge/level 10 gives high-true pulses, X1 gives low-true pulses.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module pwm_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pwm_timer_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Timer outputs
  output logic [pwm_timer_pkg::NUM_CH-1:0] o_pwm,
  output logic o_irq
);
  import pwm_timer_pkg::*;

  // ==========================================================================
  // State
  logic [7:0] sc, next_sc;
  logic [CNT_W-1:0] cnt, next_cnt, modulo_value, next_mod, init, next_init;
  logic [2:0] mode, next_mode;
  logic [31:0] pair_cfg, next_pair_cfg;
  logic [DT_W-1:0] dead, next_dead;
  logic [7:0] chcs [NUM_CH];
  logic [7:0] next_chcs [NUM_CH];
  logic [CNT_W-1:0] cv [NUM_CH];
  logic [CNT_W-1:0] next_cv [NUM_CH];
  logic [NUM_CH-1:0] oc, next_oc;
  count_dir_t dir, next_dir;
  logic next_pready, next_pslverr, next_irq;
  logic [31:0] next_prdata, rd_mux;

  // ==========================================================================
  // Decode
  logic setup, wr, ch_sel, ch_val_sel, addr_ok, run, center_active, ovf_evt;
  logic [2:0] ch_idx;
  logic [NUM_PAIR-1:0] comb_en, comp_en, decap_en, dte_en, combined;
  logic [NUM_CH-1:0] match, indep, raw, flags, ies;

  assign setup = i_psel && !i_penable;
  // Unmapped or misaligned writes are dropped here, so they can never alias onto a channel register.
  assign wr = i_psel && i_penable && o_pready && i_pwrite && addr_ok;
  assign ch_sel = i_paddr[7:6] == CH_REGION;
  assign ch_idx = i_paddr[5:3];
  assign ch_val_sel = i_paddr[2];
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (ch_sel || (i_paddr <= ADDR_SUMMARY));
  assign run = sc[SC_RUN];

  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      comb_en[p] = pair_cfg[p * PAIR_STRIDE + PF_COMBINE];
      comp_en[p] = pair_cfg[p * PAIR_STRIDE + PF_COMP];
      decap_en[p] = pair_cfg[p * PAIR_STRIDE + PF_DECAP];
      dte_en[p] = pair_cfg[p * PAIR_STRIDE + PF_DTE];
      combined[p] = mode[MODE_EXT] && !mode[MODE_QUAD] && !decap_en[p] && comb_en[p] &&
                    !sc[SC_CENTER] && comp_en[p];
    end
    for (int c = 0; c < NUM_CH; c++) begin
      flags[c] = chcs[c][CH_FLAG];
      ies[c] = chcs[c][CH_IE];
    end
  end

  // Any pair in combine or dual capture forces up-counting for the whole timer.
  assign center_active = sc[SC_CENTER] && !mode[MODE_QUAD] && !(|decap_en) && !(|comb_en);

  // ==========================================================================
  // Shared counter
  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    ovf_evt = 1'b0;
    if (wr && !ch_sel && i_paddr == ADDR_CNT) begin
      next_cnt = init;
      next_dir = DIR_UP;
    end else if (run) begin
      if (center_active) begin
        case (dir)
          DIR_UP: begin
            if (cnt >= modulo_value) begin
              next_cnt = cnt - CNT_ONE;
              next_dir = DIR_DOWN;
            end else begin
              next_cnt = cnt + CNT_ONE;
            end
          end
          DIR_DOWN: begin
            if (cnt <= init) begin
              next_cnt = cnt + CNT_ONE;
              next_dir = DIR_UP;
              ovf_evt = 1'b1;
            end else begin
              next_cnt = cnt - CNT_ONE;
            end
          end
          default: next_dir = DIR_UP;
        endcase
      end else begin
        next_dir = DIR_UP;
        if (cnt >= modulo_value) begin
          next_cnt = init;
          ovf_evt = 1'b1;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt <= INIT_RST;
      dir <= DIR_UP;
    end else begin
      cnt <= next_cnt;
      dir <= next_dir;
    end
  end

  // ==========================================================================
  // Channel levels
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      match[c] = run && (cnt == cv[c]);
      // Levels follow the counter value, so both ramps of center mode mirror each other.
      if (chcs[c][CH_ELS_HI:CH_ELS_LO] == ELS_CLEAR) begin
        indep[c] = cnt < cv[c];
      end else begin
        indep[c] = !(cnt < cv[c]);
      end
      if (!center_active && !chcs[c][CH_MS_HI]) begin
        indep[c] = oc[c];
      end
      next_oc[c] = oc[c];
      if (match[c] && !center_active && !comb_en[c / 2] && !decap_en[c / 2] &&
          chcs[c][CH_MS_HI:CH_MS_LO] == MS_COMPARE) begin
        case (chcs[c][CH_ELS_HI:CH_ELS_LO])
          ELS_TOGGLE: next_oc[c] = !oc[c];
          ELS_CLEAR: next_oc[c] = 1'b0;
          ELS_SET: next_oc[c] = 1'b1;
          default: next_oc[c] = oc[c];
        endcase
      end
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      raw[2 * p] = indep[2 * p];
      if (combined[p]) begin
        raw[2 * p] = (cnt >= cv[2 * p]) && (cnt < cv[2 * p + 1]);
        if (chcs[2 * p][CH_ELS_LO]) begin
          raw[2 * p] = !raw[2 * p];
        end
      end
      raw[2 * p + 1] = comp_en[p] ? !raw[2 * p] : indep[2 * p + 1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      oc <= BYTE_RST;
    end else begin
      oc <= next_oc;
    end
  end

  // Each output is registered inside its gap stage, so all pins share one cycle of latency.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_gap
    dead_gap u_gap (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_en(dte_en[g / 2] && comp_en[g / 2]),
      .i_len(dead),
      .i_in(raw[g]),
      .o_out(o_pwm[g])
    );
  end

  // ==========================================================================
  // Registers and APB
  always_comb begin
    next_sc = sc;
    next_mod = modulo_value;
    next_init = init;
    next_mode = mode;
    next_pair_cfg = pair_cfg;
    next_dead = dead;
    next_chcs = chcs;
    next_cv = cv;
    if (wr && !ch_sel) begin
      case (i_paddr)
        ADDR_SC: next_sc = {sc[SC_TOF] && i_pwdata[SC_TOF], i_pwdata[SC_TOF-1:0]};
        ADDR_MOD: if (mode[MODE_WPDIS]) next_mod = i_pwdata[CNT_W-1:0];
        ADDR_INIT: if (mode[MODE_WPDIS]) next_init = i_pwdata[CNT_W-1:0];
        ADDR_MODE: next_mode = i_pwdata[2:0];
        ADDR_PAIR: next_pair_cfg = i_pwdata;
        ADDR_DEAD: next_dead = i_pwdata[DT_W-1:0];
        default: next_sc = sc;
      endcase
    end else if (wr && ch_val_sel) begin
      if (mode[MODE_WPDIS]) next_cv[ch_idx] = i_pwdata[CNT_W-1:0];
    end else if (wr) begin
      next_chcs[ch_idx] = {chcs[ch_idx][CH_FLAG] && i_pwdata[CH_FLAG], i_pwdata[CH_FLAG-1:0]};
    end
    // A hardware event in the same cycle as a software clear keeps the flag set.
    if (ovf_evt) next_sc[SC_TOF] = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      if (match[c]) next_chcs[c][CH_FLAG] = 1'b1;
    end
  end

  always_comb begin
    rd_mux = WORD_RST;
    if (ch_sel) begin
      rd_mux = ch_val_sel ? {16'h0000, cv[ch_idx]} : {24'h000000, chcs[ch_idx]};
    end else begin
      case (i_paddr)
        ADDR_SC: rd_mux = {24'h000000, sc};
        ADDR_CNT: rd_mux = {16'h0000, cnt};
        ADDR_MOD: rd_mux = {16'h0000, modulo_value};
        ADDR_INIT: rd_mux = {16'h0000, init};
        ADDR_MODE: rd_mux = {29'h00000000, mode};
        ADDR_PAIR: rd_mux = pair_cfg;
        ADDR_DEAD: rd_mux = {26'h0000000, dead};
        ADDR_SUMMARY: rd_mux = {24'h000000, flags};
        default: rd_mux = WORD_RST;
      endcase
    end
    next_pready = setup;
    next_pslverr = setup && !addr_ok;
    next_prdata = (setup && !i_pwrite && addr_ok) ? rd_mux : o_prdata;
    next_irq = (|(flags & ies)) || (sc[SC_TOF] && sc[SC_OVERFLOW_IRQ_ENABLE]);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sc <= BYTE_RST;
      modulo_value <= MOD_RST;
      init <= INIT_RST;
      mode <= 3'h0;
      pair_cfg <= WORD_RST;
      dead <= DT_ZERO;
      for (int c = 0; c < NUM_CH; c++) begin
        chcs[c] <= BYTE_RST;
        cv[c] <= INIT_RST;
      end
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= WORD_RST;
      o_irq <= 1'b0;
    end else begin
      sc <= next_sc;
      modulo_value <= next_mod;
      init <= next_init;
      mode <= next_mode;
      pair_cfg <= next_pair_cfg;
      dead <= next_dead;
      chcs <= next_chcs;
      cv <= next_cv;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      o_prdata <= next_prdata;
      o_irq <= next_irq;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_center_turn: assert property (
    run && center_active && dir == DIR_UP && cnt == modulo_value && modulo_value > init && !wr
    |=> dir == DIR_DOWN && cnt == $past(cnt) - CNT_ONE)
    else $error("center counter did not turn at modulo");
  a_edge_reload: assert property (
    run && !center_active && cnt == modulo_value && !wr |=> cnt == $past(init) && sc[SC_TOF])
    else $error("edge counter did not reload at modulo");
  a_comp_inverse: assert property (
    comp_en[0] && !dte_en[0] |=> o_pwm[1] == !o_pwm[0])
    else $error("complementary pair not inverted");
  a_dead_both_low: assert property (
    $rose(raw[0]) && dte_en[0] && comp_en[0] && dead > DT_ONE |=> !o_pwm[0] [*2])
    else $error("dead interval not inserted");
  a_match_flag: assert property (
    match[3] |=> chcs[3][CH_FLAG] ##1 chcs[3][CH_FLAG] || $past(wr))
    else $error("channel flag not set on match");
  a_irq_merge: assert property (
    sc[SC_TOF] && sc[SC_OVERFLOW_IRQ_ENABLE] |=> o_irq)
    else $error("overflow did not raise the interrupt");
  a_tof_sticky: assert property (
    sc[SC_TOF] && !wr |=> sc[SC_TOF])
    else $error("overflow flag cleared without a write");
  a_summary_read: assert property (
    setup && !i_pwrite && i_paddr == ADDR_SUMMARY |=> o_pready && o_prdata[7:0] == $past(flags))
    else $error("summary read mismatch");
  a_wp_block: assert property (
    wr && i_paddr == ADDR_MOD && !mode[MODE_WPDIS] |=> modulo_value == $past(modulo_value))
    else $error("protected modulo write accepted");
  a_toggle_div: assert property (
    match[0] && !center_active && !comb_en[0] && !decap_en[0] &&
    chcs[0][CH_MS_HI:CH_MS_LO] == MS_COMPARE && chcs[0][CH_ELS_HI:CH_ELS_LO] == ELS_TOGGLE
    |=> oc[0] != $past(oc[0]))
    else $error("divider output did not toggle");

  c_center_turn: cover property (run && center_active && dir == DIR_UP ##1 dir == DIR_DOWN);
  c_combined_pulse: cover property (combined[0] && $rose(raw[0]));
  c_toggle: cover property (match[0] ##1 $changed(oc[0]));
  c_irq: cover property ($rose(o_irq));
  c_dead_rise: cover property (dte_en[0] && comp_en[0] && $rose(o_pwm[1]));

endmodule : pwm_timer

// ### test/gate_drv_model.sv
// Gate-driver side of the PWM pins: counts on-time, level changes and overlap of each leg.
// Assumes the pins change only on the timer clock; i_clr opens a fresh counting window.
`timescale 1ns/10ps
module gate_drv_model (
  // Clock and window control
  input wire logic i_clk,
  input wire logic i_clr,
  // PWM pins
  input wire logic [7:0] i_pwm,
  // Window counts
  output logic [7:0][7:0] o_hi,
  output logic [7:0][7:0] o_tog,
  output logic [3:0][7:0] o_both,
  output logic [3:0][7:0] o_same
);
  logic [7:0] last;

  // ==========================================================================
  // Counters
  always @(posedge i_clk) begin
    last <= i_pwm;
    for (int c = 0; c < 8; c++) begin
      o_hi[c] <= i_clr ? 8'h00 : o_hi[c] + 8'(i_pwm[c]);
      o_tog[c] <= i_clr ? 8'h00 : o_tog[c] + 8'(i_pwm[c] ^ last[c]);
    end
    for (int p = 0; p < 4; p++) begin
      // Both switches of one leg on together would short the supply rail.
      o_both[p] <= i_clr ? 8'h00 : o_both[p] + 8'(i_pwm[2*p] & i_pwm[2*p+1]);
      o_same[p] <= i_clr ? 8'h00 : o_same[p] + 8'(i_pwm[2*p] == i_pwm[2*p+1]);
    end
  end
endmodule : gate_drv_model

// ### test/pwm_timer_tb_top.sv
// Self-checking bench of the PWM timer: APB master tasks, one task per scenario.
// Assumes the design answers each APB access by pready and the gate-driver model watches the pins.
`timescale 1ns/10ps
module pwm_timer_tb_top;
  import pwm_timer_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic clr = 1'b0;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] prdata;
  logic [NUM_CH-1:0] pwm;
  logic [7:0][7:0] hi;
  logic [7:0][7:0] tog;
  logic [3:0][7:0] both;
  logic [3:0][7:0] same;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int n_tests = 0;

  pwm_timer u_pwm_timer (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .o_pwm(pwm), .o_irq(irq));
  gate_drv_model u_gate_drv_model (.i_clk(i_clk), .i_clr(clr), .i_pwm(pwm), .o_hi(hi), .o_tog(tog),
    .o_both(both), .o_same(same));

  initial forever #2.5 i_clk = ~i_clk;

  // ==========================================================================
  // Shared tasks
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Outputs are read right after the edge, before the design's updates of that edge land.
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task set_ch(input int n, input logic [31:0] sc, input logic [31:0] v);
    xfer(1'b1, 8'(8'h40 + 8 * n), sc);
    xfer(1'b1, 8'(8'h44 + 8 * n), v);
  endtask : set_ch

  // Stops the counter and clears its flag, loads the count range, then clears every channel setup and flag.
  task quiet(input logic [31:0] md, input logic [31:0] init);
    xfer(1'b1, ADDR_SC, 32'h0);
    xfer(1'b1, ADDR_MODE, 32'h1);
    xfer(1'b1, ADDR_PAIR, 32'h0);
    xfer(1'b1, ADDR_DEAD, 32'h0);
    xfer(1'b1, ADDR_MOD, md);
    xfer(1'b1, ADDR_INIT, init);
    xfer(1'b1, ADDR_CNT, 32'h0);
    for (int n = 0; n < 8; n++) set_ch(n, 32'h0, 32'h0);
  endtask : quiet

  // Lets the waveform settle, then counts exactly n samples of the pins.
  task window(input int n);
    repeat (16) @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (n) @(posedge i_clk);
    #1;
  endtask : window

  // ==========================================================================
  // Scenarios
  task t_reset;
    xfer(1'b0, ADDR_SC, 32'h0);
    chk(q, 32'h0);
    xfer(1'b0, ADDR_MOD, 32'h0);
    chk(q, 32'h0000_ffff);
    xfer(1'b0, ADDR_SUMMARY, 32'h0);
    chk(q, 32'h0);
    xfer(1'b0, 8'h30, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 8'h41, 32'h40);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    xfer(1'b1, ADDR_MOD, 32'h5);
    xfer(1'b0, ADDR_MOD, 32'h0);
    chk(q, 32'h0000_ffff);
  endtask : t_reset

  task t_edge;
    quiet(32'h4, 32'h1);
    set_ch(0, 32'h28, 32'h3);
    set_ch(2, 32'h24, 32'h2);
    xfer(1'b1, ADDR_SC, 32'h08);
    window(32);
    chk(hi[0], 16);
    chk(hi[2], 24);
    xfer(1'b0, ADDR_SC, 32'h0);
    chk(q, 32'h88);
    xfer(1'b0, ADDR_SC, 32'h0);
    chk(q, 32'h88);
    xfer(1'b1, ADDR_SC, 32'h48);
    repeat (8) @(posedge i_clk);
    chk({31'h0, irq}, 32'h1);
    // A wrap on the stopping edge may set the flag again, so it is cleared once more.
    xfer(1'b1, ADDR_SC, 32'h40);
    xfer(1'b1, ADDR_SC, 32'h40);
    repeat (3) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, ADDR_SC, 32'h0);
    chk(q, 32'h40);
  endtask : t_edge

  task t_comp;
    quiet(32'h7, 32'h0);
    set_ch(0, 32'h28, 32'h3);
    xfer(1'b1, ADDR_PAIR, 32'h02);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, ADDR_SC, i ? 32'h28 : 32'h08);
      window(56);
      chk(same[0], 0);
      chk(hi[0], i ? 20 : 21);
    end
    xfer(1'b1, ADDR_DEAD, 32'h2);
    xfer(1'b1, ADDR_PAIR, 32'h12);
    xfer(1'b1, ADDR_SC, 32'h08);
    window(56);
    chk(both[0], 0);
    chk(hi[0], 7);
    chk(hi[1], 21);
  endtask : t_comp

  task t_center;
    quiet(32'h3, 32'h0);
    set_ch(0, 32'h28, 32'h2);
    set_ch(2, 32'h28, 32'h1);
    xfer(1'b1, ADDR_SC, 32'h28);
    window(36);
    chk(hi[0], 18);
    chk(hi[2], 6);
    chk(tog[0], 12);
    // Combine, dual capture or quadrature each force edge counting.
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ADDR_PAIR, i == 0 ? 32'h01 : (i == 1 ? 32'h04 : 32'h00));
      xfer(1'b1, ADDR_MODE, i == 2 ? 32'h5 : 32'h1);
      window(36);
      chk(hi[2], 9);
    end
  endtask : t_center

  task t_div;
    quiet(32'h3, 32'h0);
    set_ch(0, 32'h14, 32'h1);
    set_ch(2, 32'h14, 32'h3);
    xfer(1'b1, ADDR_SC, 32'h08);
    window(32);
    chk(tog[0], 8);
    chk(tog[2], 8);
    chk(hi[0], 16);
  endtask : t_div

  task t_comb;
    logic [31:0] md [3];
    logic [31:0] sc [3];
    int ex [3];
    md = '{32'h03, 32'h01, 32'h03};
    sc = '{32'h08, 32'h08, 32'h28};
    ex = '{14, 7, 7};
    quiet(32'h7, 32'h0);
    set_ch(0, 32'h28, 32'h1);
    set_ch(1, 32'h28, 32'h3);
    xfer(1'b1, ADDR_PAIR, 32'h03);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ADDR_MODE, md[i]);
      xfer(1'b1, ADDR_SC, sc[i]);
      window(56);
      chk(hi[0], 32'(ex[i]));
      chk(hi[1], 32'(56 - ex[i]));
    end
  endtask : t_comb

  task t_flag;
    quiet(32'h3, 32'h0);
    set_ch(3, 32'h68, 32'h2);
    xfer(1'b1, ADDR_SC, 32'h08);
    repeat (8) @(posedge i_clk);
    xfer(1'b0, ADDR_SUMMARY, 32'h0);
    chk(q & 32'h08, 32'h08);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, ADDR_SC, 32'h0);
    xfer(1'b1, 8'h58, 32'h48);
    repeat (3) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, 8'h58, 32'h0);
    chk(q, 32'h48);
  endtask : t_flag

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset;
    t_edge;
    t_comp;
    t_center;
    t_div;
    t_comb;
    t_flag;
    end_sim;
  end

  initial begin
    #100us;
    bad_count++;
    end_sim;
  end
endmodule : pwm_timer_tb_top
